// ---- include/sssf_consts.svh ----
// timing counts and field constants for the supply supervisor front end
`ifndef SSSF_CONSTS_SVH
`define SSSF_CONSTS_SVH
`define SSSF_CLK_HZ        100000000
`define SSSF_RST_MS        250
`define SSSF_WD_SHORT_MS   250
`define SSSF_WD_MID_MS     750
`define SSSF_WD_LONG_MS    1750
`define SSSF_MS_CYC        (`SSSF_CLK_HZ / 1000)
`define SSSF_RST_CYC       (`SSSF_RST_MS * `SSSF_MS_CYC)
`define SSSF_WD_SHORT_CYC  (`SSSF_WD_SHORT_MS * `SSSF_MS_CYC)
`define SSSF_WD_MID_CYC    (`SSSF_WD_MID_MS * `SSSF_MS_CYC)
`define SSSF_WD_LONG_CYC   (`SSSF_WD_LONG_MS * `SSSF_MS_CYC)
`define SSSF_SPACE_ARRAY   4'hA
`define SSSF_SPACE_CTRL    4'hD
`define SSSF_SELECT_BITS   3'h7
`define SSSF_WD_OFF        2'h3
`define SSSF_WD_SHORT      2'h2
`define SSSF_WD_MID        2'h1
`define SSSF_ADDR_RST      16'h0000
`define SSSF_REG_CTRL      32'h00000000
`define SSSF_REG_STATUS    32'h00000004
`define SSSF_REG_ADDR      32'h00000008
`define SSSF_REG_RDATA     32'h0000000C
`endif

// ---- include/sssf_pkg.sv ----
// types for the supply supervisor front end
package sssf_pkg;
  typedef enum logic [3:0] {
    SSSF_IDLE  = 4'h0,
    SSSF_DEV   = 4'h1,
    SSSF_DACK  = 4'h2,
    SSSF_ADRH  = 4'h3,
    SSSF_AACKH = 4'h4,
    SSSF_ADRL  = 4'h5,
    SSSF_AACKL = 4'h6,
    SSSF_WDAT  = 4'h7,
    SSSF_WACK  = 4'h8,
    SSSF_RDAT  = 4'h9,
    SSSF_RACK  = 4'hA
  } sssf_state_t;
  typedef struct packed {
    logic mainBelowBatLo;
    logic mainAboveBatHi;
    logic mainBelowTrip;
    logic mainAboveTripHi;
    logic mainAboveReset;
  } sssf_cmp_t;
  typedef struct packed {
    logic       isWrite;
    logic       isCtrl;
    logic [15:0] addr;
    logic [7:0]  data;
  } sssf_wr_t;
endpackage

// ---- hdl/sssf_top.sv ----
// supply switchover, reset timing, watchdog and serial slave front end
//
// Notes on behaviour
// - standard: backup when below battery and trip
// - standard: back to main above either
// - policy bit zero standard, one legacy
// - legacy: run from higher supply, hysteresis
// - power-on reset held 250 ms after threshold
// - period code selects off, 250, 750, 1750 ms
// - every START reloads watchdog to full period, unless expiry falls in that cycle
// - watchdog expiry gives one reset period
// - START during reset period has no effect
// - watchdog off while on backup supply
// - low-supply reset ends 250 ms after recovery
// - write in progress finishes unless on backup (here any low-supply reset drops the frame to idle)
// - low-supply reset aborts and refuses transactions
// - backup-mode reset holds until main restored
// - ignore bus until START, STOP to standby
// - ack matching address and written bytes
// - read: release, sample ack, continue or stop
// - address byte: 1010 or 1101, 111, read bit
// - two-byte word address, counter clears to zero
// - keep sending only after ack, no stop
//
// The Wishbone slave port and the register addresses were left to the implementer.
`timescale 1ns/10ps
`include "sssf_consts.svh"
module sssf_top #(
  parameter int RST_CYC   = `SSSF_RST_CYC,
  parameter int WD_S_CYC  = `SSSF_WD_SHORT_CYC,
  parameter int WD_M_CYC  = `SSSF_WD_MID_CYC,
  parameter int WD_L_CYC  = `SSSF_WD_LONG_CYC
) (
  input  wire logic               ref_clk,
  input  wire logic               rst_n,
  input  wire sssf_pkg::sssf_cmp_t cmpIn,
  input  wire logic               nvBusy,
  input  wire logic               sclIn,
  input  wire logic               sdaIn,
  output logic                    sdaOut,
  output logic                    sdaOe,
  output logic                    resetOut_n,
  output logic                    onBackup,
  output sssf_pkg::sssf_wr_t      wrStrobeData,
  output logic                    wrStrobe,
  output logic                    rdStrobe,
  input  wire logic [7:0]         rdByte,
  input  wire logic               wb_cyc_i,
  input  wire logic               wb_stb_i,
  input  wire logic               wb_we_i,
  input  wire logic [31:0]        wb_adr_i,
  input  wire logic [3:0]         wb_sel_i,
  input  wire logic [31:0]        wb_dat_i,
  output logic [31:0]             wb_dat_o,
  output logic                    wb_ack_o
);

  // two-flop synchronisers for everything from outside the domain
  logic [4:0] cmpMeta, cmpSync;
  logic [1:0] pinMeta, pinSync;
  logic [1:0] pinLast;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cmpMeta <= 5'h00;
      cmpSync <= 5'h00;
      pinMeta <= 2'h3;
      pinSync <= 2'h3;
      pinLast <= 2'h3;
    end else begin
      cmpMeta <= cmpIn;
      cmpSync <= cmpMeta;
      pinMeta <= {sclIn, sdaIn};
      pinSync <= pinMeta;
      pinLast <= pinSync;
    end
  end

  wire sssf_pkg::sssf_cmp_t cmp = cmpSync;
  wire logic scl     = pinSync[1];
  wire logic sda     = pinSync[0];
  wire logic sclRise = scl && !pinLast[1];
  wire logic sclFall = !scl && pinLast[1];
  wire logic startEv = scl && pinLast[1] && !sda && pinLast[0];
  wire logic stopEv  = scl && pinLast[1] && sda && !pinLast[0];

  // software control: policy bit and watchdog code
  logic       policyLegacy;
  logic [1:0] wdCode;

  // supply selection with hysteresis from the comparators
  wire logic goBackStd  = cmp.mainBelowBatLo && cmp.mainBelowTrip;
  wire logic goMainStd  = cmp.mainAboveBatHi || cmp.mainAboveTripHi;
  wire logic goBack = policyLegacy ? cmp.mainBelowBatLo : goBackStd;
  wire logic goMain = policyLegacy ? cmp.mainAboveBatHi : goMainStd;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) onBackup <= 1'b0;
    else if (!onBackup && goBack) onBackup <= 1'b1;
    else if (onBackup && goMain) onBackup <= 1'b0;
  end

  // reset timing: low supply, backup latch and watchdog pulse
  logic [31:0] rstCnt;
  logic        lowReset;
  logic        backupHold;
  logic        wdPulse;
  logic [31:0] wdCnt;
  wire logic   lowNow   = !cmp.mainAboveReset;
  wire logic   rstDone  = (rstCnt == 32'h00000001);
  wire logic   wdActive = (wdCode != `SSSF_WD_OFF) && !onBackup;
  wire logic [31:0] wdFull =
    (wdCode == `SSSF_WD_SHORT) ? 32'(WD_S_CYC) :
    (wdCode == `SSSF_WD_MID)   ? 32'(WD_M_CYC) : 32'(WD_L_CYC);
  wire logic   wdExpire = wdActive && !wdPulse && !lowReset &&
                          (wdCnt == 32'h00000001);

  // low-supply reset held from power-up until 250 ms above threshold
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      lowReset   <= 1'b1;
      backupHold <= 1'b0;
      rstCnt     <= 32'(RST_CYC);
    end else begin
      if (onBackup && lowNow) backupHold <= 1'b1;
      else if (!onBackup) backupHold <= 1'b0;
      if (lowNow) begin
        lowReset <= 1'b1;
        rstCnt   <= 32'(RST_CYC);
      end else if (lowReset && rstDone) begin
        lowReset <= 1'b0;
      end else if (lowReset || wdPulse) begin
        rstCnt <= rstCnt - 32'h00000001;
      end
      if (wdExpire) rstCnt <= 32'(RST_CYC);
    end
  end

  // watchdog: reload on START, one reset period on expiry
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wdCnt   <= 32'(WD_L_CYC);
      wdPulse <= 1'b0;
    end else begin
      if (wdPulse) begin
        if (rstDone) begin
          wdPulse <= 1'b0;
          wdCnt   <= wdFull;
        end
      end else if (!wdActive || lowReset) begin
        wdCnt <= wdFull;
      end else if (wdExpire) begin
        wdPulse <= 1'b1;
      end else if (startEv) begin
        wdCnt <= wdFull;
      end else begin
        wdCnt <= wdCnt - 32'h00000001;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) resetOut_n <= 1'b0;
    else resetOut_n <= !(lowReset || backupHold || wdPulse);
  end

  // serial slave; a frame in flight is dropped to idle whenever the low-supply reset is held, on main or backup
  wire logic commsBlock = lowReset;
  wire logic nvAbort = onBackup && lowReset;
  sssf_pkg::sssf_state_t st;
  logic [7:0]  shiftReg;
  logic [3:0]  bitCnt;
  logic [15:0] addrCnt;
  logic        isRead, isCtrl;
  logic [7:0]  txByte;
  wire logic   byteDone = (bitCnt == 4'h8);
  wire logic   devMatch = (shiftReg[7:4] == `SSSF_SPACE_ARRAY ||
                           shiftReg[7:4] == `SSSF_SPACE_CTRL) &&
                          (shiftReg[3:1] == `SSSF_SELECT_BITS);
  wire logic [2:0] txIdx = 3'(4'h7 - bitCnt); // msb first after the ack

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st           <= sssf_pkg::SSSF_IDLE;
      shiftReg     <= 8'h00;
      bitCnt       <= 4'h0;
      addrCnt      <= `SSSF_ADDR_RST;
      isRead       <= 1'b0;
      isCtrl       <= 1'b0;
      txByte       <= 8'h00;
      sdaOut       <= 1'b0;
      sdaOe        <= 1'b0;
      wrStrobe     <= 1'b0;
      rdStrobe     <= 1'b0;
      wrStrobeData <= '0;
    end else begin
      wrStrobe <= 1'b0;
      rdStrobe <= 1'b0;
      if (commsBlock || stopEv) begin
        st    <= sssf_pkg::SSSF_IDLE;
        sdaOe <= 1'b0;
      end else if (startEv) begin
        st     <= sssf_pkg::SSSF_DEV;
        bitCnt <= 4'h0;
        sdaOe  <= 1'b0;
      end else begin
        if (sclRise) begin
          shiftReg <= {shiftReg[6:0], sda};
          bitCnt   <= bitCnt + 4'h1;
        end
        case (st)
          sssf_pkg::SSSF_DEV: begin
            if (byteDone && sclFall) begin
              bitCnt <= 4'h0;
              if (devMatch && !nvBusy) begin
                isRead <= shiftReg[0];
                isCtrl <= (shiftReg[7:4] == `SSSF_SPACE_CTRL);
                sdaOe  <= 1'b1;
                st     <= sssf_pkg::SSSF_DACK;
              end else begin
                st <= sssf_pkg::SSSF_IDLE;
              end
            end
          end
          sssf_pkg::SSSF_DACK: begin
            if (sclFall) begin
              sdaOe <= 1'b0;
              if (isRead) begin
                txByte   <= rdByte;
                rdStrobe <= 1'b1;
                sdaOe    <= !rdByte[7];
                st       <= sssf_pkg::SSSF_RDAT;
              end else begin
                st <= sssf_pkg::SSSF_ADRH;
              end
              bitCnt <= 4'h0;
            end
          end
          sssf_pkg::SSSF_ADRH, sssf_pkg::SSSF_ADRL,
          sssf_pkg::SSSF_WDAT: begin
            if (byteDone && sclFall) begin
              sdaOe  <= 1'b1;
              bitCnt <= 4'h0;
              if (st == sssf_pkg::SSSF_ADRH) begin
                addrCnt[15:8] <= shiftReg;
                st <= sssf_pkg::SSSF_AACKH;
              end else if (st == sssf_pkg::SSSF_ADRL) begin
                addrCnt[7:0] <= shiftReg;
                st <= sssf_pkg::SSSF_AACKL;
              end else begin
                wrStrobe     <= 1'b1;
                wrStrobeData <= {1'b1, isCtrl, addrCnt, shiftReg};
                addrCnt      <= addrCnt + 16'h0001;
                st           <= sssf_pkg::SSSF_WACK;
              end
            end
          end
          sssf_pkg::SSSF_AACKH, sssf_pkg::SSSF_AACKL,
          sssf_pkg::SSSF_WACK: begin
            if (sclFall) begin
              sdaOe  <= 1'b0;
              bitCnt <= 4'h0;
              st <= (st == sssf_pkg::SSSF_AACKH) ? sssf_pkg::SSSF_ADRL :
                    sssf_pkg::SSSF_WDAT;
            end
          end
          sssf_pkg::SSSF_RDAT: begin
            // open drain: enable drives a zero bit low
            if (sclFall) begin
              if (bitCnt == 4'h8) begin
                sdaOe   <= 1'b0;
                addrCnt <= addrCnt + 16'h0001;
                st      <= sssf_pkg::SSSF_RACK;
              end else begin
                sdaOe <= !txByte[txIdx];
              end
            end
          end
          sssf_pkg::SSSF_RACK: begin
            if (sclRise) begin
              if (sda) st <= sssf_pkg::SSSF_IDLE;
            end else if (sclFall) begin
              bitCnt   <= 4'h0;
              txByte   <= rdByte;
              rdStrobe <= 1'b1;
              sdaOe    <= !rdByte[7];
              st       <= sssf_pkg::SSSF_RDAT;
            end
          end
          default: st <= sssf_pkg::SSSF_IDLE;
        endcase
        if (nvAbort) st <= sssf_pkg::SSSF_IDLE;
      end
    end
  end

  // wishbone slave, one wait state free ack
  wire logic wbReq   = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire logic selCtrl = (wb_adr_i == `SSSF_REG_CTRL);
  wire logic selStat = (wb_adr_i == `SSSF_REG_STATUS);
  wire logic selAddr = (wb_adr_i == `SSSF_REG_ADDR);
  wire logic [31:0] rdMux =
    selCtrl ? {29'h0, policyLegacy, wdCode} :
    selStat ? {26'h0, st == sssf_pkg::SSSF_IDLE, wdPulse, backupHold,
               lowReset, onBackup, resetOut_n} :
    selAddr ? {16'h0, addrCnt} : 32'h00000000;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wb_ack_o     <= 1'b0;
      wb_dat_o     <= 32'h00000000;
      policyLegacy <= 1'b0;
      wdCode       <= 2'h0;
    end else begin
      wb_ack_o <= wbReq;
      wb_dat_o <= wbReq ? rdMux : 32'h00000000;
      if (wbReq && wb_we_i && selCtrl && wb_sel_i[0]) begin
        policyLegacy <= wb_dat_i[2];
        wdCode       <= wb_dat_i[1:0];
      end
    end
  end

endmodule // sssf_top

// ---- testbench/sssf_host_model.sv ----
// serial bus master model standing in for the host processor
`timescale 1ns/10ps
module sssf_host_model (
  output logic     sclOut,
  output logic     sdaDrv,
  input wire logic sdaBus
);
  localparam realtime Q = 31.25; // quarter of the 125 ns link period
  // clock idles high outside frames, data released to the pull-up
  initial begin
    sclOut = 1'b1;
    sdaDrv = 1'b1;
  end
  // data moves a quarter after the fall so a slave ack can let go first
  task automatic bitx(input logic o, output logic i);
    #Q sdaDrv = o;
    #Q sclOut = 1'b1;
    #Q i = sdaBus;
    #Q sclOut = 1'b0;
  endtask
  task automatic startC;
    #Q sdaDrv = 1'b1;
    #Q sclOut = 1'b1;
    #Q sdaDrv = 1'b0;
    #Q sclOut = 1'b0;
  endtask
  task automatic stopC;
    #Q sdaDrv = 1'b0;
    #Q sclOut = 1'b1;
    #Q sdaDrv = 1'b1;
  endtask
  task automatic wrB(input logic [7:0] d, output logic ack);
    for (int i = 7; i >= 0; i--) bitx(d[i], ack);
    bitx(1'b1, ack);
  endtask
  task automatic rdB(input logic nak, output logic [7:0] d);
    logic x;
    for (int i = 7; i >= 0; i--) bitx(1'b1, d[i]);
    bitx(nak, x);
  endtask
endmodule // sssf_host_model

// ---- testbench/sssf_top_props.sv ----
// port checker for the supervisor front end
`timescale 1ns/10ps
module sssf_top_props #(
  parameter int RST_CYC  = 200,
  parameter int WD_S_CYC = 300,
  parameter int WD_M_CYC = 500,
  parameter int WD_L_CYC = 800
) (
  input wire logic                ref_clk,
  input wire logic                rst_n,
  input wire sssf_pkg::sssf_cmp_t cmpIn,
  input wire logic                sclIn,
  input wire logic                sdaIn,
  input wire logic                sdaOe,
  input wire logic                resetOut_n,
  input wire logic                onBackup,
  input wire logic                wb_cyc_i,
  input wire logic                wb_we_i,
  input wire logic [31:0]         wb_adr_i,
  input wire logic [3:0]          wb_sel_i,
  input wire logic [31:0]         wb_dat_i,
  input wire logic                wb_ack_o
);
  logic       pol, busy, sdaQ;
  logic [1:0] wdCode;
  int         upCnt, lowCnt, wdCnt, per;
  // control shadow and pin events, raw pins so margins cover the syncs
  wire ctlWr = wb_cyc_i & wb_we_i & wb_ack_o & wb_sel_i[0]
             & (wb_adr_i == 32'h0);
  wire strt = sclIn & sdaQ & ~sdaIn;
  wire stp  = sclIn & ~sdaQ & sdaIn;
  assign per = wdCode == 2'h2 ? WD_S_CYC
             : wdCode == 2'h1 ? WD_M_CYC : WD_L_CYC;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      {pol, wdCode, busy, sdaQ} <= 5'h01;
      upCnt  <= 0;
      lowCnt <= 0;
      wdCnt  <= 0;
    end else begin
      if (ctlWr) {pol, wdCode} <= wb_dat_i[2:0];
      sdaQ   <= sdaIn;
      busy   <= strt | (busy & ~stp);
      upCnt  <= cmpIn.mainAboveReset ? upCnt + 1 : 0;
      lowCnt <= resetOut_n ? 0 : lowCnt + 1;
      wdCnt  <= (strt | ~resetOut_n | onBackup | ctlWr) ? 0 : wdCnt + 1;
    end
  end
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  AST_LOW_HOLD: assert property (
    (!cmpIn.mainAboveReset)[*5] |-> !resetOut_n) else $error("low reset");
  AST_REL_TIME: assert property (
    $rose(resetOut_n) |-> upCnt >= RST_CYC && lowCnt >= RST_CYC - 2)
    else $error("reset released early");
  AST_WD_LATE: assert property (
    resetOut_n && !onBackup && wdCode != 2'h3 |-> wdCnt <= per + 10)
    else $error("watchdog overdue");
  AST_WD_BACKUP: assert property (
    (onBackup && cmpIn.mainAboveReset)[*8] |=> !$fell(resetOut_n))
    else $error("watchdog reset on backup");
  AST_HOLD_BACKUP: assert property (
    onBackup && !resetOut_n |=> !resetOut_n || !onBackup)
    else $error("backup reset released");
  AST_ENTER: assert property (
    $rose(onBackup) |-> cmpIn.mainBelowBatLo && (pol || cmpIn.mainBelowTrip))
    else $error("backup entered wrongly");
  AST_LEAVE: assert property (
    onBackup && (cmpIn.mainAboveBatHi || !pol && cmpIn.mainAboveTripHi)
    |-> ##[1:6] !onBackup) else $error("backup not left");
  AST_IDLE: assert property (
    (!busy)[*6] |-> !sdaOe) else $error("data driven outside frame");
  AST_LVR_QUIET: assert property (
    (!cmpIn.mainAboveReset)[*6] |-> !sdaOe) else $error("driven in reset");
  cover property ($rose(onBackup));
  cover property ($fell(resetOut_n) && cmpIn.mainAboveReset);
  cover property ($rose(sdaOe));
endmodule // sssf_top_props
bind sssf_top sssf_top_props #(.RST_CYC(RST_CYC), .WD_S_CYC(WD_S_CYC),
  .WD_M_CYC(WD_M_CYC), .WD_L_CYC(WD_L_CYC)) props_u (.ref_clk(ref_clk),
  .rst_n(rst_n), .cmpIn(cmpIn), .sclIn(sclIn), .sdaIn(sdaIn),
  .sdaOe(sdaOe), .resetOut_n(resetOut_n), .onBackup(onBackup),
  .wb_cyc_i(wb_cyc_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o));

// ---- testbench/sssf_top_test.sv ----
// self-checking bench for the supervisor and serial front end
`timescale 1ns/10ps
module sssf_top_test;
  localparam int RC = 200;
  localparam int WS = 300;
  localparam int WM = 500;
  localparam int WL = 800;
  logic                ref_clk = 1'b0;
  logic                rst_n = 1'b0;
  sssf_pkg::sssf_cmp_t cmp = 5'b01011;
  logic                wbReq = 1'b0;
  logic                wbWe = 1'b0;
  logic [3:0]          wbSel = 4'h0;
  logic [31:0]         wbAdr = 32'h0;
  logic [31:0]         wbDat = 32'h0;
  logic [31:0]         wbQ, wbDo;
  logic                scl, sdaDrv, sdaOe, rstOut_n, onBackup, wrStb, rdStb;
  logic                sdaOut;
  logic                wbAck, a;
  logic [7:0]          b;
  sssf_pkg::sssf_wr_t  wrData, lastWr;
  int                  errorCnt = 0, checksDone = 0, rdCnt = 0, n;
  wire                 sda = sdaDrv & (sdaOut | ~sdaOe); // wired-and, pull-up
  sssf_top #(.RST_CYC(RC), .WD_S_CYC(WS), .WD_M_CYC(WM), .WD_L_CYC(WL)) dut_u (
    .ref_clk(ref_clk), .rst_n(rst_n), .cmpIn(cmp), .nvBusy(1'b0),
    .sclIn(scl), .sdaIn(sda), .sdaOut(sdaOut), .sdaOe(sdaOe),
    .resetOut_n(rstOut_n), .onBackup(onBackup), .wrStrobeData(wrData),
    .wrStrobe(wrStb), .rdStrobe(rdStb), .rdByte(8'hC3), .wb_cyc_i(wbReq),
    .wb_stb_i(wbReq), .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel),
    .wb_dat_i(wbDat), .wb_dat_o(wbDo), .wb_ack_o(wbAck));
  sssf_host_model host_u (.sclOut(scl), .sdaDrv(sdaDrv), .sdaBus(sda));
  initial forever #5 ref_clk = ~ref_clk;
  // strobe capture for the write and read paths
  always @(posedge ref_clk) begin
    if (wrStb === 1'b1) lastWr <= wrData;
    if (rdStb === 1'b1) rdCnt <= rdCnt + 1;
  end
  task chk(input logic [31:0] g, input logic [31:0] e);
    checksDone++;
    if (g !== e) begin
      errorCnt++;
      $display("mismatch at %0t: got %h exp %h", $time, g, e);
    end
  endtask
  // one classic cycle, held until ack; a hang is left to the watchdog
  task wbx(input logic w, input logic [31:0] ad, input logic [31:0] d);
    @(posedge ref_clk);
    wbReq <= 1'b1;
    wbWe <= w;
    wbAdr <= ad;
    wbDat <= d;
    wbSel <= 4'hF;
    @(posedge ref_clk);
    while (wbAck !== 1'b1) @(posedge ref_clk);
    wbQ = wbDo;
    wbReq <= 1'b0;
  endtask
  task waitRst(input logic v, output int c);
    c = 0;
    while (rstOut_n !== v && c < 3000) begin
      @(posedge ref_clk);
      c++;
    end
  endtask
  task tPower;
    repeat (RC - 20) @(posedge ref_clk);
    chk(rstOut_n, 1'b0);
    waitRst(1'b1, n);
    chk(n < 40, 1'b1);
    wbx(1'b0, 32'h4, 32'h0);
    chk(wbQ, 32'h21);
    wbx(1'b0, 32'h8, 32'h0);
    chk(wbQ, 32'h0);
    wbx(1'b0, 32'h0, 32'h0);
    chk(wbQ, 32'h0);
    wbx(1'b0, 32'h10, 32'h0);
    chk(wbQ, 32'h0);
    wbx(1'b1, 32'h0, 32'h3); // watchdog off while the bus is exercised
  endtask
  task tSerial;
    logic [7:0] sb [4] = '{8'hDE, 8'hBE, 8'hAC, 8'hA0};
    host_u.wrB(8'hAE, a);
    chk(a, 1'b1);
    host_u.stopC;
    host_u.startC;
    host_u.wrB(8'hAF, a);
    chk(a, 1'b0);
    host_u.rdB(1'b0, b);
    chk(b, 8'hC3);
    host_u.rdB(1'b1, b);
    host_u.stopC;
    chk(rdCnt, 2);
    for (int i = 0; i < 4; i++) begin
      host_u.startC;
      host_u.wrB(sb[i], a);
      host_u.stopC;
      chk(a, i != 0);
    end
    host_u.startC;
    host_u.wrB(8'hAE, a);
    host_u.wrB(8'h01, a);
    host_u.wrB(8'h23, a);
    host_u.wrB(8'h5A, a);
    host_u.stopC;
    chk(a, 1'b0);
    chk(lastWr, {1'b1, 1'b0, 16'h0123, 8'h5A});
    // random read: dummy write of the word address, then a repeated start
    host_u.startC;
    host_u.wrB(8'hAE, a);
    host_u.wrB(8'h00, a);
    host_u.wrB(8'h40, a);
    host_u.startC;
    host_u.wrB(8'hAF, a);
    chk(a, 1'b0);
    host_u.rdB(1'b1, b);
    host_u.stopC;
    chk(b, 8'hC3);
    wbx(1'b0, 32'h8, 32'h0);
    chk(wbQ, 32'h41);
  endtask
  task tWatchdog;
    int per [3] = '{WS, WM, WL};
    for (int i = 0; i < 3; i++) begin
      wbx(1'b1, 32'h0, 32'(2 - i)); // codes 10, 01, 00
      host_u.startC;
      host_u.stopC;
      repeat (per[i] / 2) @(posedge ref_clk);
      host_u.startC;
      host_u.stopC;
      waitRst(1'b0, n);
      chk(n >= per[i] - 20 && n <= per[i] + 5, 1'b1);
      host_u.startC;
      host_u.stopC;
      waitRst(1'b1, n);
      chk(n >= RC - 27 && n <= RC - 16, 1'b1);
    end
    wbx(1'b1, 32'h0, 32'h3);
    repeat (WL + 100) @(posedge ref_clk);
    chk(rstOut_n, 1'b1);
  endtask
  task tSupply;
    cmp <= 5'b10011;
    repeat (20) @(posedge ref_clk);
    chk(onBackup, 1'b0);
    cmp <= 5'b10101;
    repeat (20) @(posedge ref_clk);
    chk(onBackup, 1'b1);
    wbx(1'b1, 32'h0, 32'h2);
    repeat (WS + 100) @(posedge ref_clk);
    chk(rstOut_n, 1'b1);
    wbx(1'b1, 32'h0, 32'h3);
    cmp <= 5'b10100;
    repeat (10) @(posedge ref_clk);
    chk(rstOut_n, 1'b0);
    cmp <= 5'b10101;
    repeat (RC + 50) @(posedge ref_clk);
    chk(rstOut_n, 1'b0);
    cmp <= 5'b10011;
    repeat (10) @(posedge ref_clk);
    chk(onBackup, 1'b0);
    waitRst(1'b1, n);
    chk(n < 5, 1'b1);
    cmp <= 5'b01010;
    repeat (10) @(posedge ref_clk);
    host_u.startC;
    host_u.wrB(8'hAF, a);
    host_u.stopC;
    chk(a, 1'b1);
    @(posedge ref_clk);
    cmp <= 5'b01011;
    waitRst(1'b1, n);
    chk(n >= RC && n <= RC + 10, 1'b1);
    wbx(1'b1, 32'h0, 32'h7);
    cmp <= 5'b10011;
    repeat (20) @(posedge ref_clk);
    chk(onBackup, 1'b1);
    cmp <= 5'b01011;
    repeat (20) @(posedge ref_clk);
    chk(onBackup, 1'b0);
  endtask
  task testDone;
    if (errorCnt == 0 && checksDone > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // cut a hang short well past the expected run length
  initial begin
    repeat (40000) @(posedge ref_clk);
    errorCnt++;
    testDone;
  end
  initial begin
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
    tPower;
    tSerial;
    tWatchdog;
    tSupply;
    testDone;
  end
endmodule // sssf_top_test
